// >>> design/iod_decoder.sv
// apb instruction operand decoder top
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
module iod_decoder
  import iod_pkg::*;
(
  input  wire logic        core_clk_i,          // 10 mhz core clock
  input  wire logic        sys_rst_i,           // sync reset, high
  input  wire logic        psel_i,              // apb select
  input  wire logic        penable_i,           // apb enable
  input  wire logic        pwrite_i,            // apb write
  input  wire logic [7:0]  paddr_i,             // apb byte address
  input  wire logic [31:0] pwdata_i,            // apb write data
  input  wire logic [3:0]  pstrb_i,             // apb byte strobes
  output logic      [31:0] prdata_o,            // apb read data
  output logic             pready_o,            // apb ready
  output logic             pslverr_o,           // apb error
  output logic      [12:0] pc_o,                // program address
  output logic             pc_load_o,           // jump load pulse
  output logic      [7:0]  alu_operand_o,       // alu second operand
  output logic      [7:0]  left_bank_select_o,  // left bank device
  output logic      [7:0]  right_bank_select_o  // right bank device
);

  typedef struct packed {
    logic [15:0] instr;
    logic        exec;
    logic [7:0]  aux;
    logic        carry_out_register;
    logic [7:0]  wreg;
    logic [7:0]  io_left;
    logic [7:0]  io_right;
    logic [12:0] pc;
    logic        pc_load;
    logic [7:0]  lsel;
    logic [7:0]  rsel;
    logic [7:0]  result;
    logic [7:0]  mask;
    iod_kind_t   skind;
    iod_kind_t   dkind;
    logic        jump;
    logic        serr;
    logic        derr;
    logic        iomode;
    logic [2:0]  rl;
    logic [2:0]  opc;
    logic [7:0]  literal;
    logic        lit5;
    logic [31:0] prdata;
  } iod_state_t;

  iod_state_t  st_q;
  iod_state_t  st_d;
  logic        hit;
  logic [31:0] rd_val;
  logic [31:0] status_w;
  logic [2:0]  opc;
  logic [4:0]  src;
  logic [4:0]  dst;
  logic [2:0]  rl;
  iod_kind_t   sk;
  iod_kind_t   dk;
  logic        sio;
  logic        dio;
  logic        serr;
  logic        derr;
  logic [7:0]  src_val;
  logic [7:0]  fu_value;
  logic [7:0]  fu_mask;
  logic [7:0]  fu_place;
  logic        wr;
  logic [31:0] wdat;
  logic [31:0] instr_w;

  function automatic iod_kind_t kind_of(input logic [4:0] c);
    if (c[4:3] == IO_LEFT_HI) begin
      kind_of = K_IOL;
    end else if (c[4:3] == IO_RIGHT_HI) begin
      kind_of = K_IOR;
    end else if (c == CODE_AUX) begin
      kind_of = K_AUX;
    end else if (c == CODE_LEFT_SELECT) begin
      kind_of = K_LSEL;
    end else if (c == CODE_CARRY_OUT) begin
      kind_of = K_CARRY;
    end else if (c == CODE_RIGHT_SELECT) begin
      kind_of = K_RSEL;
    end else if ((c >= CODE_WORK_LO && c <= CODE_WORK_HI) ||
                 c == CODE_WORKING_REGISTER_NINE) begin
      kind_of = K_WORK;
    end else begin
      kind_of = K_NONE;
    end
  endfunction

  // merge only the strobed byte lanes
  function automatic logic [31:0] lanes(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    lanes = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        lanes[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // field split of the held instruction
  always_comb begin
    opc  = st_q.instr[OPC_LO +: 3];
    src  = st_q.instr[SRC_LO +: 5];
    rl   = st_q.instr[RL_LO +: 3];
    dst  = st_q.instr[DST_LO +: 5];
    sk   = kind_of(src);
    dk   = kind_of(dst);
    sio  = (sk == K_IOL) || (sk == K_IOR);
    dio  = (dk == K_IOL) || (dk == K_IOR);
    serr = (sk == K_LSEL) || (sk == K_RSEL);
    derr = (dk == K_CARRY);
    case (sk)
      K_AUX:   src_val = st_q.aux;
      K_WORK:  src_val = st_q.wreg;
      K_CARRY: src_val = 8'({7'h00, st_q.carry_out_register} << CARRY_BIT);
      K_IOL:   src_val = st_q.io_left;
      K_IOR:   src_val = st_q.io_right;
      default: src_val = RST_BYTE;
    endcase
  end

  iod_field_unit u_field (
    .src_i     (src_val),
    .rl_i      (rl),
    .src_pos_i (src[2:0]),
    .dst_pos_i (dst[2:0]),
    .src_io_i  (sio),
    .dst_io_i  (dio),
    .value_o   (fu_value),
    .mask_o    (fu_mask),
    .place_o   (fu_place)
  );

  always_comb begin
    status_w                   = 32'h0000_0000;
    status_w[ST_SKIND +: 3]    = st_q.skind;
    status_w[ST_DKIND +: 3]    = st_q.dkind;
    status_w[ST_JUMP]          = st_q.jump;
    status_w[ST_SERR]          = st_q.serr;
    status_w[ST_DERR]          = st_q.derr;
    status_w[ST_IOMODE]        = st_q.iomode;
    status_w[ST_RL +: 3]       = st_q.rl;
    status_w[ST_OPC +: 3]      = st_q.opc;
    status_w[ST_LIT +: 8]      = st_q.literal;
    status_w[ST_LIT5]          = st_q.lit5;
  end

  // address decode for both read mux and error answer
  always_comb begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    if (paddr_i == OFF_INSTR) begin
      rd_val = {16'h0000, st_q.instr};
    end else if (paddr_i == OFF_AUX) begin
      rd_val = {24'h00_0000, st_q.aux};
    end else if (paddr_i == OFF_CARRY_OUT) begin
      rd_val[CARRY_BIT] = st_q.carry_out_register;
    end else if (paddr_i == OFF_WREG) begin
      rd_val = {24'h00_0000, st_q.wreg};
    end else if (paddr_i == OFF_IODATA) begin
      rd_val = {16'h0000, st_q.io_right, st_q.io_left};
    end else if (paddr_i == OFF_STATUS) begin
      rd_val = status_w;
    end else if (paddr_i == OFF_PC) begin
      rd_val = {19'h0_0000, st_q.pc};
    end else if (paddr_i == OFF_BANK) begin
      rd_val = {16'h0000, st_q.rsel, st_q.lsel};
    end else if (paddr_i == OFF_RESULT) begin
      rd_val = {16'h0000, st_q.mask, st_q.result};
    end else begin
      hit = 1'b0;
    end
  end

  always_comb begin
    st_d         = st_q;
    st_d.exec    = 1'b0;
    st_d.pc_load = 1'b0;
    wr           = psel_i && penable_i && pwrite_i && hit;
    wdat         = lanes(32'h0000_0000, pwdata_i, pstrb_i);
    instr_w      = lanes({16'h0000, st_q.instr}, pwdata_i, pstrb_i);
    // read data captured in setup so it stands through the access phase
    if (psel_i && !penable_i) begin
      st_d.prdata = rd_val;
    end
    if (wr) begin
      if (paddr_i == OFF_INSTR) begin
        st_d.instr = instr_w[15:0];
        st_d.exec  = 1'b1;
      end else if (paddr_i == OFF_AUX && pstrb_i[0]) begin
        st_d.aux = wdat[7:0];
      end else if (paddr_i == OFF_CARRY_OUT && pstrb_i[0]) begin
        st_d.carry_out_register = wdat[CARRY_BIT];
      end else if (paddr_i == OFF_WREG && pstrb_i[0]) begin
        st_d.wreg = wdat[7:0];
      end else if (paddr_i == OFF_IODATA) begin
        if (pstrb_i[0]) begin
          st_d.io_left = wdat[7:0];
        end
        if (pstrb_i[1]) begin
          st_d.io_right = wdat[15:8];
        end
      end
    end
    // execution outranks a software write in the same cycle
    if (st_q.exec) begin
      st_d.jump = (opc == OPC_JUMP);
      st_d.opc  = opc;
      if (opc == OPC_JUMP) begin
        st_d.pc      = st_q.instr[ADDR_LO +: 13];
        st_d.pc_load = 1'b1;
      end else begin
        st_d.skind   = sk;
        st_d.dkind   = dk;
        st_d.serr    = serr;
        st_d.derr    = derr;
        st_d.rl      = rl;
        st_d.iomode  = sio || dio;
        st_d.result  = fu_value;
        st_d.mask    = fu_mask;
        st_d.lit5    = sio && (opc >= OPC_XEC_LO);
        if (sio && (opc >= OPC_XEC_LO)) begin
          st_d.literal = {3'h0, st_q.instr[LIT5_LO +: 5]};
        end else begin
          st_d.literal = st_q.instr[LIT8_LO +: 8];
        end
        // illegal source or destination codes move nothing
        if (opc <= OPC_XFER_MAX && !serr && !derr) begin
          case (dk)
            K_AUX:   st_d.aux  = fu_value;
            K_LSEL:  st_d.lsel = fu_value;
            K_RSEL:  st_d.rsel = fu_value;
            K_IOL:   st_d.io_left  = (st_q.io_left & ~fu_mask) | fu_place;
            K_IOR:   st_d.io_right = (st_q.io_right & ~fu_mask) | fu_place;
            default: st_d.wreg = st_q.wreg;
          endcase
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata_o            = st_q.prdata;
  assign pready_o            = 1'b1;
  assign pslverr_o           = psel_i && penable_i && !hit;
  assign pc_o                = st_q.pc;
  assign pc_load_o           = st_q.pc_load;
  assign alu_operand_o       = st_q.aux;
  assign left_bank_select_o  = st_q.lsel;
  assign right_bank_select_o = st_q.rsel;

  logic [15:0] aux_rot;
  assign aux_rot = {st_q.aux, st_q.aux} >> rl;

  jump_load_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc == OPC_JUMP |=>
      pc_load_o && pc_o == $past(st_q.instr[12:0]) ##1 !pc_load_o)
    else $error("jump did not load the program address");

  field_split_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc != OPC_JUMP |=>
      st_q.rl == $past(st_q.instr[7:5]) &&
      st_q.skind == kind_of($past(st_q.instr[12:8])))
    else $error("operand fields split wrongly");

  aux_write_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc <= OPC_XFER_MAX && dst == CODE_AUX && !serr |=>
      alu_operand_o == st_q.result)
    else $error("aux destination not written");

  work_kind_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc != OPC_JUMP && src == CODE_WORKING_REGISTER_NINE |=>
      st_q.skind == K_WORK)
    else $error("working register code misdecoded");

  left_sel_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc <= OPC_XFER_MAX && dst == CODE_LEFT_SELECT && !serr
      |=> left_bank_select_o == st_q.result)
    else $error("left bank select not written");

  right_src_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc != OPC_JUMP && src == CODE_RIGHT_SELECT |=>
      st_q.serr && $stable(right_bank_select_o))
    else $error("right select accepted as source");

  carry_read_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc != OPC_JUMP && src == CODE_CARRY_OUT &&
      rl == 3'h0 && !dio |=>
      st_q.result == 8'({7'h00, $past(st_q.carry_out_register)}
                        << CARRY_BIT))
    else $error("carry read in wrong position");

  io_bank_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc != OPC_JUMP && src[4] |=>
      st_q.skind == ($past(src[3]) ? K_IOR : K_IOL))
    else $error("i/o bank misdecoded");

  field_pos_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc != OPC_JUMP && dio |=>
      st_q.mask[BYTE_MSB - $past(dst[2:0])] && st_q.mask != 8'h00)
    else $error("i/o field position wrong");

  rotate_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc != OPC_JUMP && sk == K_AUX && dk == K_WORK |=>
      st_q.result == $past(aux_rot[7:0]) && !st_q.iomode)
    else $error("register rotate wrong");

  length_mode_a: assert property (
    @(posedge core_clk_i) disable iff (sys_rst_i)
    st_q.exec && opc >= OPC_XEC_LO && opc <= OPC_XEC_HI && sio |=>
      st_q.iomode && st_q.lit5 && st_q.literal[7:5] == 3'h0)
    else $error("i/o length mode or literal wrong");

endmodule // iod_decoder

// >>> design/iod_pkg.sv
// constants and types shared by the instruction operand decoder
package iod_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFF_INSTR     = 8'h00;
  localparam logic [7:0] OFF_AUX       = 8'h04;
  localparam logic [7:0] OFF_CARRY_OUT = 8'h08;
  localparam logic [7:0] OFF_WREG      = 8'h0c;
  localparam logic [7:0] OFF_IODATA    = 8'h10;
  localparam logic [7:0] OFF_STATUS    = 8'h14;
  localparam logic [7:0] OFF_PC        = 8'h18;
  localparam logic [7:0] OFF_BANK      = 8'h1c;
  localparam logic [7:0] OFF_RESULT    = 8'h20;

  // instruction fields, bit 0 of the format is word bit 15
  localparam int OPC_LO  = 13;
  localparam int SRC_LO  = 8;
  localparam int RL_LO   = 5;
  localparam int DST_LO  = 0;
  localparam int ADDR_LO = 0;
  localparam int LIT8_LO = 0;
  localparam int LIT5_LO = 0;

  localparam logic [2:0] OPC_JUMP     = 3'h7;
  localparam logic [2:0] OPC_XFER_MAX = 3'h3;
  localparam logic [2:0] OPC_XEC_LO   = 3'h4;
  localparam logic [2:0] OPC_XEC_HI   = 3'h6;

  // operand codes
  localparam logic [4:0] CODE_AUX                   = 5'h00;
  localparam logic [4:0] CODE_WORK_LO               = 5'h01;
  localparam logic [4:0] CODE_WORK_HI               = 5'h06;
  localparam logic [4:0] CODE_LEFT_SELECT           = 5'h07;
  localparam logic [4:0] CODE_CARRY_OUT             = 5'h08;
  localparam logic [4:0] CODE_WORKING_REGISTER_NINE = 5'h09;
  localparam logic [4:0] CODE_RIGHT_SELECT          = 5'h0f;
  localparam logic [1:0] IO_LEFT_HI                 = 2'h2;
  localparam logic [1:0] IO_RIGHT_HI                = 2'h3;

  // carry sits at format bit 7, the least significant bit
  localparam int         CARRY_BIT     = 0;
  localparam logic [2:0] BYTE_MSB      = 3'h7;
  localparam logic [2:0] LEN_FULL_CODE = 3'h0;
  localparam logic [3:0] LEN_FULL      = 4'h8;

  // status register field positions
  localparam int ST_SKIND  = 0;
  localparam int ST_DKIND  = 3;
  localparam int ST_JUMP   = 6;
  localparam int ST_SERR   = 7;
  localparam int ST_DERR   = 8;
  localparam int ST_IOMODE = 9;
  localparam int ST_RL     = 10;
  localparam int ST_OPC    = 13;
  localparam int ST_LIT    = 16;
  localparam int ST_LIT5   = 24;

  // reset values
  localparam logic [15:0] RST_INSTR = 16'h0000;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [12:0] RST_PC    = 13'h0000;

  typedef enum logic [2:0] {
    K_AUX   = 3'h0,
    K_WORK  = 3'h1,
    K_LSEL  = 3'h2,
    K_CARRY = 3'h3,
    K_NONE  = 3'h4,
    K_RSEL  = 3'h5,
    K_IOL   = 3'h6,
    K_IOR   = 3'h7
  } iod_kind_t;

endpackage

// >>> design/iod_field_unit.sv
// rotate and bit field extract/place for one operand transfer
`timescale 1ns/1ns
module iod_field_unit
  import iod_pkg::*;
(
  input  wire logic [7:0] src_i,     // source byte
  input  wire logic [2:0] rl_i,      // rotate/length operand
  input  wire logic [2:0] src_pos_i, // source low digit
  input  wire logic [2:0] dst_pos_i, // destination low digit
  input  wire logic       src_io_i,  // source is an i/o field
  input  wire logic       dst_io_i,  // destination is an i/o field
  output logic      [7:0] value_o,   // right aligned value
  output logic      [7:0] mask_o,    // field mask in the byte
  output logic      [7:0] place_o    // value placed under mask, or right aligned when only the source is i/o
);

  logic [15:0] dbl;
  logic [3:0]  len;
  logic [2:0]  sshift;
  logic [2:0]  dshift;
  logic [8:0]  lmask9;
  logic [7:0]  lmask;

  always_comb begin
    dbl    = {src_i, src_i} >> rl_i;
    len    = (rl_i == LEN_FULL_CODE) ? LEN_FULL : {1'b0, rl_i};
    sshift = BYTE_MSB - src_pos_i;
    dshift = BYTE_MSB - dst_pos_i;
    lmask9 = (9'h001 << len) - 9'h001;
    lmask  = lmask9[7:0];
    if (!src_io_i && !dst_io_i) begin
      value_o = dbl[7:0];
      mask_o  = 8'hff;
      place_o = dbl[7:0];
    end else begin
      value_o = src_io_i ? ((src_i >> sshift) & lmask) : (src_i & lmask);
      if (dst_io_i) begin
        mask_o  = 8'(lmask << dshift);
        place_o = 8'(value_o << dshift) & mask_o;
      end else begin
        mask_o  = src_io_i ? 8'(lmask << sshift) : lmask;
        place_o = value_o;
      end
    end
  end

endmodule // iod_field_unit

// >>> tb/iod_store_model.sv
// program storage and bank device stand-in fed by decoder outputs
`timescale 1ns/1ns
module iod_store_model
  import iod_pkg::*;
(
  input  wire logic        core_clk_i, // core clock
  input  wire logic        sys_rst_i,  // sync reset, high
  input  wire logic [12:0] pc_i,       // program address
  input  wire logic        pc_load_i,  // jump load pulse
  input  wire logic [7:0]  lsel_i,     // left bank select
  input  wire logic [7:0]  rsel_i,     // right bank select
  output logic      [12:0] fetch_o,    // address last fetched
  output logic      [7:0]  jumps_o,    // jumps seen
  output logic      [15:0] dev_o       // enabled devices, right:left
);
  // storage only fetches on the pulse, a stale pc is never taken
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      fetch_o <= RST_PC;
      jumps_o <= 8'h00;
    end else if (pc_load_i) begin
      fetch_o <= pc_i;
      jumps_o <= jumps_o + 8'h01;
    end
  end
  assign dev_o = {rsel_i, lsel_i};
endmodule // iod_store_model

// >>> tb/test_instruction_operand_decoder.sv
// self-checking bench for the instruction operand decoder
`timescale 1ns/1ns
module test_instruction_operand_decoder
  import iod_pkg::*;
;
  logic        clk, rst, psel, pen, pwr, rdy, serr, pcl, err;
  logic [7:0]  paddr, alu, lsel, rsel, jumps;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [12:0] pc, fetch;
  logic [15:0] dev;
  int          error_cnt, n_tests, cycles;

  iod_decoder i_dut (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(rdy), .pslverr_o(serr),
    .pc_o(pc), .pc_load_o(pcl), .alu_operand_o(alu),
    .left_bank_select_o(lsel), .right_bank_select_o(rsel));
  iod_store_model i_store (.core_clk_i(clk), .sys_rst_i(rst), .pc_i(pc),
    .pc_load_i(pcl), .lsel_i(lsel), .rsel_i(rsel), .fetch_o(fetch),
    .jumps_o(jumps), .dev_o(dev));

  always #50 clk = ~clk;

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt = error_cnt + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    // only the bench timeout ends a wait for ready
    while (rdy !== 1'b1) begin
      @(posedge clk);
    end
    rd   = prdata;
    err  = serr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  function automatic logic [15:0] ins(logic [2:0] op, logic [4:0] s,
                                      logic [2:0] rl, logic [4:0] d);
    return {op, s, rl, d};
  endfunction

  // run one word, stop just after the execute edge has landed
  task automatic exec(input logic [15:0] w);
    apb(1'b1, OFF_INSTR, {16'h0000, w});
    @(negedge clk);
    @(negedge clk);
  endtask

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic t_reset();
    chk("outs", 32'h0, {11'h0, pc, pcl, alu});
    chk("sels", 32'h0, {16'h0, lsel, rsel});
    rchk("status", OFF_STATUS, 32'h0);
    rchk("bank", OFF_BANK, 32'h0);
    apb(1'b1, OFF_PC, 32'h0000_1234);
    rchk("pc ro", OFF_PC, 32'h0);
    chk("no slverr", 32'h0, {31'h0, err});
    apb(1'b1, 8'h40, 32'h1);
    chk("slverr", 32'h1, {31'h0, err});
    rchk("unmapped", 8'h40, 32'h0);
    chk("slverr rd", 32'h1, {31'h0, err});
  endtask

  task automatic t_jump();
    exec(16'hfabc);
    chk("pc_load", 32'h1, {31'h0, pcl});
    chk("pc", 32'h1abc, {19'h0, pc});
    @(negedge clk);
    chk("pc_load end", 32'h0, {31'h0, pcl});
    chk("fetch", 32'h1abc, {19'h0, fetch});
    chk("jumps", 32'h1, {24'h0, jumps});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("jump st", 32'hf, {28'h0, rd[15:13], rd[6]});
  endtask

  task automatic t_select();
    apb(1'b1, OFF_WREG, 32'h5a);
    exec(ins(3'h0, 5'h01, 3'h0, 5'h07));
    chk("left sel", 32'h5a, {24'h0, lsel});
    exec(ins(3'h0, 5'h01, 3'h0, 5'h0f));
    chk("devices", 32'h5a5a, {16'h0, dev});
    // nonzero aux so a wrongly accepted source would show
    apb(1'b1, OFF_AUX, 32'h33);
    exec(ins(3'h0, 5'h07, 3'h0, 5'h00));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("src err", 32'h1, {31'h0, rd[7]});
    chk("aux kept", 32'h33, {24'h0, alu});
    exec(ins(3'h0, 5'h0f, 3'h0, 5'h00));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("src err r", 32'h1, {31'h0, rd[7]});
    exec(ins(3'h0, 5'h01, 3'h0, 5'h08));
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("dst err", 32'h1, {31'h0, rd[8]});
  endtask

  task automatic t_regs();
    exec(ins(3'h0, 5'h01, 3'h3, 5'h00));
    chk("rotate", 32'h4b, {24'h0, alu});
    rchk("aux", OFF_AUX, 32'h4b);
    apb(1'b1, OFF_CARRY_OUT, 32'h1);
    exec(ins(3'h0, 5'h08, 3'h0, 5'h00));
    chk("carry", 32'h01, {24'h0, alu});
  endtask

  task automatic t_io();
    apb(1'b1, OFF_IODATA, 32'h3ca5);
    exec(ins(3'h0, 5'h17, 3'h3, 5'h00));
    chk("left fld", 32'h05, {24'h0, alu});
    exec(ins(3'h0, 5'h14, 3'h4, 5'h00));
    chk("left mid", 32'h04, {24'h0, alu});
    exec(ins(3'h0, 5'h1f, 3'h0, 5'h00));
    chk("right fld", 32'h3c, {24'h0, alu});
    exec(ins(3'h0, 5'h00, 3'h4, 5'h17));
    rchk("placed", OFF_IODATA, 32'h3cac);
    rchk("result", OFF_RESULT, 32'h0f0c);
  endtask

  task automatic t_kinds();
    logic [4:0] codes [7];
    logic [2:0] kinds [7];
    codes = '{5'h00, 5'h03, 5'h09, 5'h08, 5'h0a, 5'h12, 5'h1b};
    kinds = '{K_AUX, K_WORK, K_WORK, K_CARRY, K_NONE, K_IOL, K_IOR};
    for (int i = 0; i < 7; i++) begin
      exec(ins(3'h0, codes[i], 3'h5, 5'h0c));
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("kinds", {23'h0, 3'h5, K_NONE, kinds[i]},
          {23'h0, rd[12:10], rd[5:0]});
    end
    exec(16'h81c3);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("lit8", 32'h0c3, {23'h0, rd[24:16]});
    exec(16'h975f);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("lit5", 32'h11f, {23'h0, rd[24:16]});
  endtask

  initial begin
    clk       = 1'b0;
    rst       = 1'b1;
    psel      = 1'b0;
    pen       = 1'b0;
    pwr       = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    pstrb     = 4'hf;
    error_cnt = 0;
    n_tests   = 0;
    cycles    = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    t_reset();
    t_jump();
    t_select();
    t_regs();
    t_io();
    t_kinds();
    complete_run();
  end
endmodule // test_instruction_operand_decoder
